// file: hdl/simd_manip_pkg.sv
package simd_manip_pkg;

  typedef enum logic [4:0] {
    OP_BYTE_SELECT          = 5'h00,
    OP_BYTE_SELECT_NEGATED  = 5'h01,
    OP_EXTRACT_ONE          = 5'h02,
    OP_EXTRACT_TWO          = 5'h03,
    OP_EXTRACT_THREE        = 5'h04,
    OP_DYN_EXTRACT_LITTLE   = 5'h05,
    OP_DYN_EXTRACT_BIG      = 5'h06,
    OP_TRUNC_BYTE_PACK      = 5'h07,
    OP_ROUND_HIGH_PACK      = 5'h08,
    OP_SIGNED_HALF_SAT_PACK = 5'h09,
    OP_UNSIGNED_BYTE_PACK   = 5'h0a,
    OP_BYTE_PERMUTE         = 5'h0b,
    OP_BYTE_SHUFFLE_HIGH    = 5'h0c,
    OP_BYTE_SHUFFLE_LOW     = 5'h0d,
    OP_HALF_SHUFFLE_HIGH    = 5'h0e,
    OP_HALF_SHUFFLE_LOW     = 5'h0f,
    OP_EVEN_BYTE_SHUFFLE    = 5'h10,
    OP_ODD_BYTE_SHUFFLE     = 5'h11,
    OP_UNPACK_HIGH          = 5'h12,
    OP_UNPACK_LOW           = 5'h13,
    OP_BYTE_EQUAL_CMP       = 5'h14,
    OP_BYTE_UGT_CMP         = 5'h15,
    OP_HALF_EQUAL_CMP       = 5'h16,
    OP_HALF_SGT_CMP         = 5'h17
  } op_t;

  // Halfword pack shares the low halfword shuffle encoding
  localparam op_t OP_HALFWORD_PACK_ALIAS = OP_HALF_SHUFFLE_LOW;

  localparam int          LATENCY_CYCLES = 1;
  localparam logic [31:0] GPR_RESET      = 32'h0000_0000;
  localparam logic [3:0]  BR_RESET       = 4'h0;
  localparam logic [15:0] HALF_MAX       = 16'h7fff;
  localparam logic [15:0] HALF_MIN       = 16'h8000;
  localparam logic [32:0] ROUND_BIAS     = 33'h0_0000_8000;

  typedef struct packed {
    op_t         op;
    logic        use_imm;
    logic        to_branch;
    logic [3:0]  cond;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] imm;
  } req_t;

  typedef struct packed {
    logic        to_branch;
    logic [3:0]  br;
    logic [31:0] gpr;
  } res_t;

endpackage

// file: hdl/simd_byte_manipulation_unit.sv
`timescale 1ns/100ps
module simd_byte_manipulation_unit (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Issue side
  input  wire logic                 issue_valid,
  input  wire simd_manip_pkg::req_t issue_req,
  // Writeback side
  output logic                      result_valid,
  output simd_manip_pkg::res_t      result
);

  function automatic logic [31:0] extract_le(input logic [63:0] cat, input logic [1:0] off);
    logic [63:0] sh;
    sh = cat >> {off, 3'b000};
    return sh[31:0];
  endfunction

  function automatic logic [15:0] sat_half(input logic [31:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (!v[31] && (v[31:15] != 17'h0_0000)) begin
      r = simd_manip_pkg::HALF_MAX;
    end else if (v[31] && (v[31:15] != 17'h1_ffff)) begin
      r = simd_manip_pkg::HALF_MIN;
    end
    return r;
  endfunction

  function automatic logic [15:0] round_high(input logic [31:0] v);
    logic [32:0] s;
    logic [15:0] r;
    s = {v[31], v} + simd_manip_pkg::ROUND_BIAS;
    r = s[31:16];
    // Positive overflow would wrap to negative
    if (!s[32] && s[31]) begin
      r = simd_manip_pkg::HALF_MAX;
    end
    return r;
  endfunction

  function automatic logic [7:0] sat_ubyte(input logic [15:0] v);
    logic [7:0] r;
    r = v[7:0];
    if (v[15]) begin
      r = 8'h00;
    end else if (v[14:8] != 7'h00) begin
      r = 8'hff;
    end
    return r;
  endfunction

  function automatic logic [31:0] interleave(input logic [31:0] a, input logic [31:0] b,
                                             input logic [1:0] lo, input logic [1:0] hi);
    return {b[8*hi +: 8], a[8*hi +: 8], b[8*lo +: 8], a[8*lo +: 8]};
  endfunction

  simd_manip_pkg::req_t q;
  logic [31:0]          opnd_b;
  logic [31:0]          opnd_neg;
  logic [31:0]          sel_out;
  logic [31:0]          nsel_out;
  logic [31:0]          perm_out;
  logic [63:0]          cat_le;
  logic [63:0]          cat_be;
  logic [63:0]          be_shift;
  logic [31:0]          dyn_be_out;
  logic [3:0]           beq;
  logic [3:0]           bgt;
  logic [1:0]           heq;
  logic [1:0]           hgt;
  logic [31:0]          gpr_nxt;
  logic [3:0]           br_nxt;
  simd_manip_pkg::res_t result_r;
  logic                 result_valid_r;

  assign q      = issue_req;
  assign opnd_b = q.use_imm ? q.imm : q.src2;
  // Only an immediate form exists, so the immediate is always taken
  assign opnd_neg = q.imm;
  assign cat_le = {q.src2, q.src1};
  assign cat_be = {q.src1, q.src2};
  assign be_shift   = cat_be << {q.cond[1:0], 3'b000};
  assign dyn_be_out = be_shift[63:32];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_byte
      assign sel_out[8*gi +: 8]  = q.cond[gi] ? q.src1[8*gi +: 8] : opnd_b[8*gi +: 8];
      assign nsel_out[8*gi +: 8] = q.cond[gi] ? opnd_neg[8*gi +: 8] : q.src1[8*gi +: 8];
      assign perm_out[8*gi +: 8] = q.src1[8*opnd_b[2*gi +: 2] +: 8];
      assign beq[gi] = q.src1[8*gi +: 8] == opnd_b[8*gi +: 8];
      assign bgt[gi] = q.src1[8*gi +: 8] >  opnd_b[8*gi +: 8];
    end
    for (gi = 0; gi < 2; gi++) begin : g_half
      assign heq[gi] = q.src1[16*gi +: 16] == opnd_b[16*gi +: 16];
      assign hgt[gi] = $signed(q.src1[16*gi +: 16]) > $signed(opnd_b[16*gi +: 16]);
    end
  endgenerate

  always_comb begin
    gpr_nxt = simd_manip_pkg::GPR_RESET;
    br_nxt  = simd_manip_pkg::BR_RESET;
    case (q.op)
      simd_manip_pkg::OP_BYTE_SELECT:          gpr_nxt = sel_out;
      simd_manip_pkg::OP_BYTE_SELECT_NEGATED:  gpr_nxt = nsel_out;
      simd_manip_pkg::OP_EXTRACT_ONE:          gpr_nxt = extract_le(cat_le, 2'd1);
      simd_manip_pkg::OP_EXTRACT_TWO:          gpr_nxt = extract_le(cat_le, 2'd2);
      simd_manip_pkg::OP_EXTRACT_THREE:        gpr_nxt = extract_le(cat_le, 2'd3);
      // Offset zero falls out as src1 in both orders
      simd_manip_pkg::OP_DYN_EXTRACT_LITTLE:   gpr_nxt = extract_le(cat_le, q.cond[1:0]);
      simd_manip_pkg::OP_DYN_EXTRACT_BIG:      gpr_nxt = dyn_be_out;
      simd_manip_pkg::OP_TRUNC_BYTE_PACK:
        gpr_nxt = {opnd_b[23:16], opnd_b[7:0], q.src1[23:16], q.src1[7:0]};
      simd_manip_pkg::OP_ROUND_HIGH_PACK:
        gpr_nxt = {round_high(opnd_b), round_high(q.src1)};
      simd_manip_pkg::OP_SIGNED_HALF_SAT_PACK:
        gpr_nxt = {sat_half(opnd_b), sat_half(q.src1)};
      simd_manip_pkg::OP_UNSIGNED_BYTE_PACK:
        gpr_nxt = {sat_ubyte(opnd_b[31:16]), sat_ubyte(opnd_b[15:0]),
                   sat_ubyte(q.src1[31:16]), sat_ubyte(q.src1[15:0])};
      simd_manip_pkg::OP_BYTE_PERMUTE:         gpr_nxt = perm_out;
      simd_manip_pkg::OP_BYTE_SHUFFLE_HIGH:    gpr_nxt = interleave(q.src1, opnd_b, 2'd2, 2'd3);
      simd_manip_pkg::OP_BYTE_SHUFFLE_LOW:     gpr_nxt = interleave(q.src1, opnd_b, 2'd0, 2'd1);
      simd_manip_pkg::OP_HALF_SHUFFLE_HIGH:    gpr_nxt = {opnd_b[31:16], q.src1[31:16]};
      // Also serves as the halfword pack
      simd_manip_pkg::OP_HALF_SHUFFLE_LOW:     gpr_nxt = {opnd_b[15:0], q.src1[15:0]};
      simd_manip_pkg::OP_EVEN_BYTE_SHUFFLE:    gpr_nxt = interleave(q.src1, opnd_b, 2'd0, 2'd2);
      simd_manip_pkg::OP_ODD_BYTE_SHUFFLE:     gpr_nxt = interleave(q.src1, opnd_b, 2'd1, 2'd3);
      // Unpacks reuse the byte shuffles against a zero operand
      simd_manip_pkg::OP_UNPACK_HIGH:          gpr_nxt = interleave(q.src1, 32'h0000_0000, 2'd2, 2'd3);
      simd_manip_pkg::OP_UNPACK_LOW:           gpr_nxt = interleave(q.src1, 32'h0000_0000, 2'd0, 2'd1);
      simd_manip_pkg::OP_BYTE_EQUAL_CMP: begin
        br_nxt  = beq;
        gpr_nxt = {7'h00, beq[3], 7'h00, beq[2], 7'h00, beq[1], 7'h00, beq[0]};
      end
      simd_manip_pkg::OP_BYTE_UGT_CMP: begin
        br_nxt  = bgt;
        gpr_nxt = {7'h00, bgt[3], 7'h00, bgt[2], 7'h00, bgt[1], 7'h00, bgt[0]};
      end
      simd_manip_pkg::OP_HALF_EQUAL_CMP: begin
        br_nxt  = {heq[1], heq[1], heq[0], heq[0]};
        gpr_nxt = {15'h0000, heq[1], 15'h0000, heq[0]};
      end
      simd_manip_pkg::OP_HALF_SGT_CMP: begin
        br_nxt  = {hgt[1], hgt[1], hgt[0], hgt[0]};
        gpr_nxt = {15'h0000, hgt[1], 15'h0000, hgt[0]};
      end
      // Unknown opcodes give zero rather than trapping
      default: gpr_nxt = simd_manip_pkg::GPR_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_valid_r <= 1'b0;
      result_r       <= '0;
    end else begin
      result_valid_r <= issue_valid;
      result_r       <= '{to_branch: q.to_branch, br: br_nxt, gpr: gpr_nxt};
    end
  end

  assign result_valid = result_valid_r;
  assign result       = result_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_latency;
    issue_valid |=> result_valid ##1 (result_valid == $past(issue_valid));
  endproperty
  a_latency: assert property (p_latency) else $error("result not one cycle after issue");

  property p_dyn_zero;
    issue_valid && (q.op inside {simd_manip_pkg::OP_DYN_EXTRACT_LITTLE, simd_manip_pkg::OP_DYN_EXTRACT_BIG})
      && (q.cond[1:0] == 2'd0) |=> result.gpr == $past(q.src1);
  endproperty
  a_dyn_zero: assert property (p_dyn_zero) else $error("zero offset extract changed src1");

  property p_dyn_little_hi;
    issue_valid && q.op == simd_manip_pkg::OP_DYN_EXTRACT_LITTLE && q.cond == 4'hf
      |=> result.gpr == {$past(q.src2[23:0]), $past(q.src1[31:24])};
  endproperty
  a_dyn_little_hi: assert property (p_dyn_little_hi) else $error("little extract wrong or upper bits used");

  property p_dyn_big;
    issue_valid && q.op == simd_manip_pkg::OP_DYN_EXTRACT_BIG && q.cond[1:0] == 2'd1
      |=> result.gpr == {$past(q.src1[23:0]), $past(q.src2[31:24])};
  endproperty
  a_dyn_big: assert property (p_dyn_big) else $error("big extract byte order wrong");

  property p_ext_two;
    issue_valid && q.op == simd_manip_pkg::OP_EXTRACT_TWO
      |=> result.gpr == {$past(q.src2[15:0]), $past(q.src1[31:16])};
  endproperty
  a_ext_two: assert property (p_ext_two) else $error("static extract two wrong");

  property p_perm_bcast;
    issue_valid && q.op == simd_manip_pkg::OP_BYTE_PERMUTE && q.use_imm && q.imm[7:0] == 8'hff
      |=> result.gpr == {4{$past(q.src1[31:24])}};
  endproperty
  a_perm_bcast: assert property (p_perm_bcast) else $error("permute broadcast wrong");

  property p_perm_rev;
    issue_valid && q.op == simd_manip_pkg::OP_BYTE_PERMUTE && !q.use_imm && q.src2[7:0] == 8'h1b
      |=> result.gpr == {$past(q.src1[7:0]), $past(q.src1[15:8]), $past(q.src1[23:16]), $past(q.src1[31:24])};
  endproperty
  a_perm_rev: assert property (p_perm_rev) else $error("permute reversal wrong");

  property p_select;
    issue_valid && q.op == simd_manip_pkg::OP_BYTE_SELECT && q.cond == 4'h5
      |=> result.gpr == {$past(opnd_b[31:24]), $past(q.src1[23:16]), $past(opnd_b[15:8]), $past(q.src1[7:0])};
  endproperty
  a_select: assert property (p_select) else $error("byte select picked wrong source");

  property p_neg_select;
    issue_valid && q.op == simd_manip_pkg::OP_BYTE_SELECT_NEGATED && q.cond == 4'hf
      |=> result.gpr == $past(q.imm);
  endproperty
  a_neg_select: assert property (p_neg_select) else $error("negated select not opposite");

  property p_sat_half;
    issue_valid && q.op == simd_manip_pkg::OP_SIGNED_HALF_SAT_PACK && q.src1 == 32'h8000_0000
      |=> result.gpr[15:0] == 16'h8000;
  endproperty
  a_sat_half: assert property (p_sat_half) else $error("signed pack not clamped");

  property p_round_max;
    issue_valid && q.op == simd_manip_pkg::OP_ROUND_HIGH_PACK && q.src1 == 32'h7fff_ffff
      |=> result.gpr[15:0] == 16'h7fff;
  endproperty
  a_round_max: assert property (p_round_max) else $error("rounding pack wrapped");

  property p_usat;
    issue_valid && q.op == simd_manip_pkg::OP_UNSIGNED_BYTE_PACK && q.src1[15] |=> result.gpr[7:0] == 8'h00;
  endproperty
  a_usat: assert property (p_usat) else $error("negative half not clamped to zero");

  property p_trunc;
    issue_valid && q.op == simd_manip_pkg::OP_TRUNC_BYTE_PACK |=> result.gpr[15:0] == $past({q.src1[23:16], q.src1[7:0]});
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncating pack wrong");

  property p_half_cmp;
    issue_valid && q.op inside {simd_manip_pkg::OP_HALF_EQUAL_CMP, simd_manip_pkg::OP_HALF_SGT_CMP}
      |=> result.br[3] == result.br[2] && result.br[1] == result.br[0] && (result.gpr & 32'hfffe_fffe) == 32'h0;
  endproperty
  a_half_cmp: assert property (p_half_cmp) else $error("half compare fields not replicated");

  property p_byte_cmp;
    issue_valid && q.op == simd_manip_pkg::OP_BYTE_EQUAL_CMP && q.src1 == opnd_b
      |=> result.br == 4'hf && result.gpr == 32'h0101_0101;
  endproperty
  a_byte_cmp: assert property (p_byte_cmp) else $error("byte equality result wrong");

  property p_unpack;
    issue_valid && q.op == simd_manip_pkg::OP_UNPACK_LOW |=> (result.gpr & 32'hff00_ff00) == 32'h0;
  endproperty
  a_unpack: assert property (p_unpack) else $error("unpack upper bytes not zero");

  property p_ext_three;
    issue_valid && q.op == simd_manip_pkg::OP_EXTRACT_THREE
      |=> result.gpr == {$past(q.src2[23:0]), $past(q.src1[31:24])};
  endproperty
  a_ext_three: assert property (p_ext_three) else $error("static extract three wrong");

  property p_half_pack;
    issue_valid && q.op == simd_manip_pkg::OP_HALFWORD_PACK_ALIAS
      |=> result.gpr == {$past(opnd_b[15:0]), $past(q.src1[15:0])};
  endproperty
  a_half_pack: assert property (p_half_pack) else $error("halfword pack not low halves");

  property p_shuffle_low;
    issue_valid && q.op == simd_manip_pkg::OP_BYTE_SHUFFLE_LOW
      |=> result.gpr == {$past(opnd_b[15:8]), $past(q.src1[15:8]), $past(opnd_b[7:0]), $past(q.src1[7:0])};
  endproperty
  a_shuffle_low: assert property (p_shuffle_low) else $error("low byte shuffle order wrong");

  property p_even_shuffle;
    issue_valid && q.op == simd_manip_pkg::OP_EVEN_BYTE_SHUFFLE
      |=> result.gpr == {$past(opnd_b[23:16]), $past(q.src1[23:16]), $past(opnd_b[7:0]), $past(q.src1[7:0])};
  endproperty
  a_even_shuffle: assert property (p_even_shuffle) else $error("even byte shuffle wrong");

  property p_ugt_cmp;
    issue_valid && q.op == simd_manip_pkg::OP_BYTE_UGT_CMP
      |=> (result.gpr & 32'hfefe_fefe) == 32'h0000_0000
          && result.br == {result.gpr[24], result.gpr[16], result.gpr[8], result.gpr[0]};
  endproperty
  a_ugt_cmp: assert property (p_ugt_cmp) else $error("byte compare fields disagree");

  property p_idle_no_result;
    !issue_valid |=> !result_valid;
  endproperty
  a_idle_no_result: assert property (p_idle_no_result) else $error("result without issue");

  c_dyn_big: cover property (issue_valid && q.op == simd_manip_pkg::OP_DYN_EXTRACT_BIG && q.cond[1:0] == 2'd3);
  c_select: cover property (issue_valid && q.op == simd_manip_pkg::OP_BYTE_SELECT && q.use_imm);
  c_back2back: cover property (issue_valid ##1 issue_valid ##1 result_valid);
  c_half_cmp_br: cover property (issue_valid && q.op == simd_manip_pkg::OP_HALF_SGT_CMP && q.to_branch);

endmodule // simd_byte_manipulation_unit

// file: testbench/issue_pipe_model.sv
`timescale 1ns/100ps
module issue_pipe_model (
  // Clock
  input  wire logic                 clk,
  // Issue side
  output simd_manip_pkg::req_t      issue_req,
  output logic                      issue_valid,
  // Writeback side
  input  wire logic                 result_valid,
  input  wire simd_manip_pkg::res_t result
);
  initial begin
    issue_valid = 1'b0;
    issue_req   = '0;
  end

  // Issue lands at the falling edge; the result is read just after the next rising edge
  // Calling send on consecutive cycles keeps valid high, giving back-to-back issue
  task automatic send(input simd_manip_pkg::req_t r, output logic v, output simd_manip_pkg::res_t res);
    @(negedge clk);
    issue_valid = 1'b1;
    issue_req   = r;
    @(posedge clk);
    #1;
    v   = result_valid;
    res = result;
  endtask

  // Stale operands are scrambled, a real pipeline leaves no useful value behind
  task automatic idle(output logic v);
    @(negedge clk);
    issue_valid = 1'b0;
    issue_req   = ~issue_req;
    @(posedge clk);
    #1;
    v = result_valid;
  endtask
endmodule // issue_pipe_model

// file: testbench/tb_simd_byte_manipulation_unit.sv
`timescale 1ns/100ps
module tb_simd_byte_manipulation_unit;
  logic                 clk;
  logic                 resetn;
  logic                 issue_valid;
  logic                 result_valid;
  simd_manip_pkg::req_t issue_req;
  simd_manip_pkg::res_t result;
  int                   fail_count = 0;
  int                   checks     = 0;
  int                   cycles     = 0;
  localparam logic [31:0] a_word = 32'h44332211;
  localparam logic [31:0] b_word = 32'h88776655;

  simd_byte_manipulation_unit simd_byte_manipulation_unit_inst (.clk(clk), .resetn(resetn),
    .issue_valid(issue_valid), .issue_req(issue_req), .result_valid(result_valid), .result(result));
  issue_pipe_model issue_pipe_model_inst (.clk(clk), .issue_req(issue_req), .issue_valid(issue_valid),
    .result_valid(result_valid), .result(result));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Whole run needs about 50 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      $display("mismatch at %0t: run hung", $time);
      stop_test;
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Second operand goes to imm or src2; the unused one carries its inverse so a wrong pick shows
  task automatic go(input simd_manip_pkg::op_t op, input logic ui, input logic [3:0] c, input logic [31:0] a,
                    input logic [31:0] b, input logic [31:0] eg, input logic [3:0] eb);
    simd_manip_pkg::req_t r;
    logic                 v;
    simd_manip_pkg::res_t res;
    r = '{op: op, use_imm: ui, to_branch: |eb, cond: c, src1: a, src2: ui ? ~b : b, imm: ui ? b : ~b};
    issue_pipe_model_inst.send(r, v, res);
    chk1(v, 1'b1, "result valid");
    chk32(res.gpr, eg, "general result");
    chk4(res.br, eb, "branch result");
    chk1(res.to_branch, r.to_branch, "destination kind");
  endtask

  task automatic t_select;
    go(simd_manip_pkg::OP_BYTE_SELECT, 1'b0, 4'h5, a_word, b_word, 32'h88336611, 4'h0);
    go(simd_manip_pkg::OP_BYTE_SELECT, 1'b1, 4'h5, a_word, 32'hddccbbaa, 32'hdd33bb11, 4'h0);
    go(simd_manip_pkg::OP_BYTE_SELECT_NEGATED, 1'b1, 4'h5, a_word, 32'hddccbbaa, 32'h44cc22aa, 4'h0);
    go(simd_manip_pkg::OP_BYTE_SELECT_NEGATED, 1'b1, 4'hf, a_word, 32'hddccbbaa, 32'hddccbbaa, 4'h0);
    // Register-form negated select: plain select with sources swapped
    go(simd_manip_pkg::OP_BYTE_SELECT, 1'b0, 4'h5, b_word, a_word, 32'h44772255, 4'h0);
    $display("test select done");
  endtask

  // Reset lands while a result still stands, so the clear must be asynchronous
  task automatic t_reset;
    @(negedge clk);
    resetn = 1'b0;
    #1;
    chk1(result_valid, 1'b0, "valid in mid reset");
    chk32(result.gpr, simd_manip_pkg::GPR_RESET, "result in mid reset");
    chk4(result.br, simd_manip_pkg::BR_RESET, "branch in mid reset");
    @(negedge clk);
    resetn = 1'b1;
    $display("test reset done");
  endtask

  task automatic t_permute;
    go(simd_manip_pkg::OP_BYTE_PERMUTE, 1'b0, 4'h0, a_word, 32'h0000001b, 32'h11223344, 4'h0);
    go(simd_manip_pkg::OP_BYTE_PERMUTE, 1'b1, 4'h0, a_word, 32'h0000001b, 32'h11223344, 4'h0);
    go(simd_manip_pkg::OP_BYTE_PERMUTE, 1'b0, 4'h0, a_word, 32'h00000000, 32'h11111111, 4'h0);
    go(simd_manip_pkg::OP_BYTE_PERMUTE, 1'b1, 4'h0, a_word, 32'h000000e4, a_word, 4'h0);
    go(simd_manip_pkg::OP_BYTE_PERMUTE, 1'b1, 4'h0, a_word, 32'h000000ff, 32'h44444444, 4'h0);
    $display("test permute done");
  endtask

  task automatic t_extract;
    go(simd_manip_pkg::OP_EXTRACT_ONE, 1'b0, 4'hf, a_word, b_word, 32'h55443322, 4'h0);
    go(simd_manip_pkg::OP_EXTRACT_TWO, 1'b0, 4'hf, a_word, b_word, 32'h66554433, 4'h0);
    go(simd_manip_pkg::OP_EXTRACT_THREE, 1'b0, 4'h0, a_word, b_word, 32'h77665544, 4'h0);
    go(simd_manip_pkg::OP_DYN_EXTRACT_LITTLE, 1'b0, 4'he, a_word, b_word, 32'h66554433, 4'h0);
    go(simd_manip_pkg::OP_DYN_EXTRACT_LITTLE, 1'b0, 4'hc, a_word, b_word, a_word, 4'h0);
    go(simd_manip_pkg::OP_DYN_EXTRACT_LITTLE, 1'b0, 4'hf, a_word, b_word, 32'h77665544, 4'h0);
    go(simd_manip_pkg::OP_DYN_EXTRACT_BIG, 1'b0, 4'h5, a_word, b_word, 32'h33221188, 4'h0);
    go(simd_manip_pkg::OP_DYN_EXTRACT_BIG, 1'b0, 4'h3, a_word, b_word, 32'h11887766, 4'h0);
    go(simd_manip_pkg::OP_DYN_EXTRACT_BIG, 1'b0, 4'h8, a_word, b_word, a_word, 4'h0);
    $display("test extract done");
  endtask

  task automatic t_pack;
    go(simd_manip_pkg::OP_TRUNC_BYTE_PACK, 1'b0, 4'h0, a_word, b_word, 32'h77553311, 4'h0);
    go(simd_manip_pkg::OP_SIGNED_HALF_SAT_PACK, 1'b0, 4'h0, 32'h00012345, 32'hfffe0000, 32'h80007fff, 4'h0);
    go(simd_manip_pkg::OP_SIGNED_HALF_SAT_PACK, 1'b1, 4'h0, 32'hffffff80, 32'h00001234, 32'h1234ff80, 4'h0);
    go(simd_manip_pkg::OP_SIGNED_HALF_SAT_PACK, 1'b0, 4'h0, 32'h80000000, 32'h7fffffff, 32'h7fff8000, 4'h0);
    go(simd_manip_pkg::OP_ROUND_HIGH_PACK, 1'b0, 4'h0, 32'h7fffffff, 32'h00018000, 32'h00027fff, 4'h0);
    go(simd_manip_pkg::OP_ROUND_HIGH_PACK, 1'b0, 4'h0, 32'h00017fff, 32'hffff8000, 32'h00000001, 4'h0);
    go(simd_manip_pkg::OP_UNSIGNED_BYTE_PACK, 1'b0, 4'h0, 32'h0123ff80, 32'h007f0080, 32'h7f80ff00, 4'h0);
    go(simd_manip_pkg::OP_HALFWORD_PACK_ALIAS, 1'b0, 4'h0, a_word, b_word, 32'h66552211, 4'h0);
    $display("test pack done");
  endtask

  task automatic t_shuffle;
    go(simd_manip_pkg::OP_BYTE_SHUFFLE_HIGH, 1'b0, 4'h0, a_word, b_word, 32'h88447733, 4'h0);
    go(simd_manip_pkg::OP_BYTE_SHUFFLE_LOW, 1'b1, 4'h0, a_word, b_word, 32'h66225511, 4'h0);
    go(simd_manip_pkg::OP_EVEN_BYTE_SHUFFLE, 1'b1, 4'h0, a_word, b_word, 32'h77335511, 4'h0);
    go(simd_manip_pkg::OP_ODD_BYTE_SHUFFLE, 1'b0, 4'h0, a_word, b_word, 32'h88446622, 4'h0);
    go(simd_manip_pkg::OP_HALF_SHUFFLE_HIGH, 1'b0, 4'h0, a_word, b_word, 32'h88774433, 4'h0);
    go(simd_manip_pkg::OP_HALF_SHUFFLE_LOW, 1'b1, 4'h0, a_word, b_word, 32'h66552211, 4'h0);
    go(simd_manip_pkg::OP_UNPACK_HIGH, 1'b0, 4'h0, a_word, b_word, 32'h00440033, 4'h0);
    go(simd_manip_pkg::OP_UNPACK_LOW, 1'b0, 4'h0, a_word, b_word, 32'h00220011, 4'h0);
    $display("test shuffle done");
  endtask

  task automatic t_compare;
    logic v;
    go(simd_manip_pkg::OP_BYTE_EQUAL_CMP, 1'b0, 4'h0, a_word, 32'h44aa2200, 32'h01000100, 4'ha);
    go(simd_manip_pkg::OP_BYTE_EQUAL_CMP, 1'b1, 4'h0, a_word, a_word, 32'h01010101, 4'hf);
    go(simd_manip_pkg::OP_BYTE_UGT_CMP, 1'b1, 4'h0, 32'h80017f00, 32'h7f02ff00, 32'h01000000, 4'h8);
    go(simd_manip_pkg::OP_HALF_EQUAL_CMP, 1'b0, 4'h0, 32'h12345678, 32'h12340000, 32'h00010000, 4'hc);
    go(simd_manip_pkg::OP_HALF_SGT_CMP, 1'b0, 4'h0, 32'h80000001, 32'h7fff0000, 32'h00000001, 4'h3);
    // Unmapped opcode answers zeros without stalling the stream
    go(simd_manip_pkg::op_t'(5'h1f), 1'b0, 4'hf, a_word, b_word, 32'h00000000, 4'h0);
    issue_pipe_model_inst.idle(v);
    chk1(v, 1'b0, "valid after idle");
    $display("test compare done");
  endtask

  initial begin
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk1(result_valid, 1'b0, "valid in reset");
    chk32(result.gpr, simd_manip_pkg::GPR_RESET, "result in reset");
    @(negedge clk);
    resetn = 1'b1;
    t_select;
    t_reset;
    t_permute;
    t_extract;
    t_pack;
    t_shuffle;
    t_compare;
    stop_test;
  end
endmodule // tb_simd_byte_manipulation_unit
